/* File: dv/gcf_checker.sv */
// Port assertions of the graphics command buffer
`timescale 1ns/1ps
`default_nettype none
module gcf_checker #(
	parameter int DEPTH = 1024,
	parameter int HALF_LEVEL = 512
) (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	// Host side
	input wire gcf_pkg::gcf_host_req_t i_host,
	input wire logic o_host_ack,
	input wire logic o_local_mode,
	// Processor side
	input wire gcf_pkg::gcf_dp_t o_dp0,
	input wire logic i_dp0_ready,
	input wire gcf_pkg::gcf_dp_t o_dp1,
	input wire logic i_dp1_ready,
	// Interrupt
	input wire logic [2:0] i_irq_level,
	input wire logic [7:0] i_irq_vector,
	input wire logic [2:0] o_irq_level,
	input wire logic [7:0] o_irq_vector,
	input wire logic o_half_full,
	input wire logic [$clog2(DEPTH):0] o_fill_count
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_b);
	AST_FILL_MAX: assert property (o_fill_count <= DEPTH)
		else $error("fill count above depth");
	AST_HALF_SET: assert property (o_fill_count >= HALF_LEVEL |-> o_half_full)
		else $error("half-full missing");
	AST_HALF_CLR: assert property (o_fill_count < HALF_LEVEL |-> !o_half_full)
		else $error("half-full stuck");
	AST_IRQ_ON: assert property (o_half_full && $past(o_half_full) && $stable(i_irq_level)
		|-> o_irq_level == i_irq_level) else $error("request level wrong");
	AST_IRQ_OFF: assert property (!o_half_full && !$past(o_half_full)
		|-> o_irq_level == 3'h0) else $error("request without half-full");
	AST_VECTOR: assert property (1'b1 |=> o_irq_vector == $past(i_irq_vector))
		else $error("vector not forwarded");
	AST_LOCAL: assert property (o_local_mode && $past(o_local_mode) |-> !o_host_ack)
		else $error("ack in local mode");
	AST_ACK_CAUSE: assert property (o_host_ack |-> $past(i_host.valid) ##1 !o_host_ack)
		else $error("ack without request");
	AST_DP0_HOLD: assert property (o_dp0.valid && !i_dp0_ready |=> o_dp0.valid && $stable(o_dp0.data))
		else $error("processor 0 word lost");
	AST_DP1_HOLD: assert property (o_dp1.valid && !i_dp1_ready |=> o_dp1.valid && $stable(o_dp1.data))
		else $error("processor 1 word lost");
	COV_HALF: cover property ($rose(o_half_full));
	COV_FULL: cover property (o_fill_count == DEPTH);
	COV_BOTH: cover property (o_dp0.valid && o_dp1.valid);
endmodule
`default_nettype wire

/* File: dv/gcf_host_model.sv */
// Host bus master model: holds one write until acknowledged
`timescale 1ns/1ps
`default_nettype none
module gcf_host_model (
	// Clock and command
	input wire logic i_clk_sys,
	input wire logic i_go,
	input wire gcf_pkg::gcf_host_req_t i_req,
	// Bus side
	input wire logic i_ack,
	output gcf_pkg::gcf_host_req_t o_host
);
	initial o_host = '0;
	always @(posedge i_clk_sys) begin
		if (i_go) begin
			o_host <= i_req;
		end else if (i_ack) begin
			// Released bus must not keep stale data
			o_host <= '{1'b0, ~o_host.fifo_sel, ~o_host.target, ~o_host.data};
		end
	end
endmodule
`default_nettype wire

/* File: dv/gcf_test.sv */
// Self-checking bench of the graphics command buffer
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_mismatch++; \
$display("Error t=%0t got %0h exp %0h", $time, a, b); end end
module gcf_test;
	logic clk, rst_b, go, sw, ack, lmode, half;
	logic [1:0] rdy;
	logic [2:0] lvl;
	logic [7:0] vec;
	logic [10:0] fill;
	gcf_pkg::gcf_host_req_t req, host;
	gcf_pkg::gcf_dp_t dp0, dp1;
	logic go_s, ack_s, lmode_s, rdy_s;
	logic [2:0] irq_lvl;
	logic [7:0] irq_vec;
	logic [10:0] fill_s;
	gcf_pkg::gcf_host_req_t req_s, host_s;
	gcf_pkg::gcf_dp_t dp0_s, dp1_s;
	int n_mismatch = 0;
	int comparisons = 0;
	gcf_top i_dut (.i_clk_sys(clk), .i_rst_b(rst_b), .i_host(host), .o_host_ack(ack),
		.i_local_sw(sw), .o_local_mode(lmode), .o_dp0(dp0), .i_dp0_ready(rdy[0]),
		.o_dp1(dp1), .i_dp1_ready(rdy[1]), .i_irq_level(irq_lvl), .i_irq_vector(irq_vec),
		.o_irq_level(lvl), .o_irq_vector(vec), .o_half_full(half), .o_fill_count(fill));
	gcf_host_model u_host (.i_clk_sys(clk), .i_go(go), .i_req(req), .i_ack(ack), .o_host(host));
	// Single-processor variant, 16-bit entries
	gcf_top #(.DUAL(1'b0)) i_dut_single (.i_clk_sys(clk), .i_rst_b(rst_b), .i_host(host_s),
		.o_host_ack(ack_s), .i_local_sw(sw), .o_local_mode(lmode_s), .o_dp0(dp0_s),
		.i_dp0_ready(rdy_s), .o_dp1(dp1_s), .i_dp1_ready(1'b0), .i_irq_level(irq_lvl),
		.i_irq_vector(irq_vec), .o_irq_level(), .o_irq_vector(), .o_half_full(),
		.o_fill_count(fill_s));
	gcf_host_model u_host_s (.i_clk_sys(clk), .i_go(go_s), .i_req(req_s), .i_ack(ack_s),
		.o_host(host_s));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic wr(input logic s, input logic [1:0] t, input logic [31:0] d, input logic e);
		int k;
		logic got;
		@(posedge clk) begin go <= 1'b1; req <= '{1'b1, s, t, d}; end
		@(posedge clk) go <= 1'b0;
		got = 1'b0;
		for (k = 0; k < 20 && !got; k++) begin
			@(negedge clk) got = ack;
		end
		`CHK(got, e)
		if (!got) begin
			// Refused write is withdrawn by the host
			@(posedge clk) begin go <= 1'b1; req <= '{1'b0, 1'b0, 2'h0, ~d}; end
			@(posedge clk) go <= 1'b0;
			@(negedge clk);
		end
	endtask
	task automatic pop(input int n, input logic [15:0] e);
		gcf_pkg::gcf_dp_t p;
		p = n ? dp1 : dp0;
		for (int k = 0; k < 50 && !p.valid; k++) begin
			@(negedge clk) p = n ? dp1 : dp0;
		end
		`CHK({p.valid, p.data}, {1'b1, e})
		@(posedge clk) rdy[n] <= 1'b1;
		@(posedge clk) rdy[n] <= 1'b0;
		@(negedge clk);
	endtask
	task automatic t_direct;
		wr(1'b0, 2'h3, 32'hBEEF1234, 1'b1);
		`CHK({dp0.valid, dp1.valid, fill}, {2'h3, 11'h000})
		pop(0, 16'h1234);
		pop(1, 16'hBEEF);
		$display("direct test done");
	endtask
	task automatic t_buffer;
		wr(1'b1, 2'h1, 32'h0000AAAA, 1'b1);
		wr(1'b1, 2'h2, 32'hBBBB0000, 1'b1);
		wr(1'b1, 2'h3, 32'hCCCC1111, 1'b1);
		wr(1'b1, 2'h0, 32'h00002222, 1'b1);
		pop(0, 16'hAAAA);
		pop(1, 16'hBBBB);
		pop(0, 16'h1111);
		pop(1, 16'hCCCC);
		pop(0, 16'h2222);
		$display("buffer test done");
	endtask
	task automatic t_single;
		@(posedge clk) begin go_s <= 1'b1; req_s <= '{1'b1, 1'b1, 2'h2, 32'hDEAD5A5A}; end
		@(posedge clk) go_s <= 1'b0;
		repeat (2) @(negedge clk);
		`CHK(ack_s, 1'b1)
		repeat (3) @(negedge clk);
		`CHK({dp0_s, dp1_s.valid, fill_s}, {1'b1, 16'h5A5A, 1'b0, 11'h000})
		@(posedge clk) rdy_s <= 1'b1;
		@(posedge clk) begin rdy_s <= 1'b0; go_s <= 1'b1; req_s <= '{1'b1, 1'b0, 2'h3, 32'h12349876}; end
		@(posedge clk) go_s <= 1'b0;
		repeat (2) @(negedge clk);
		`CHK({ack_s, dp0_s, dp1_s.valid}, {1'b1, 1'b1, 16'h9876, 1'b0})
		@(posedge clk) rdy_s <= 1'b1;
		@(posedge clk) rdy_s <= 1'b0;
		$display("single test done");
	endtask
	task automatic t_local;
		@(posedge clk) sw <= 1'b1;
		repeat (5) @(negedge clk);
		`CHK({lmode, lmode_s}, 2'h3)
		wr(1'b1, 2'h1, 32'h00003333, 1'b0);
		`CHK(fill, 11'h000)
		@(posedge clk) sw <= 1'b0;
		repeat (6) @(negedge clk);
		`CHK({lmode, lmode_s}, 2'h0)
		$display("local test done");
	endtask
	task automatic t_half;
		for (int i = 0; i < 1100 && fill < 11'd511; i++) wr(1'b1, 2'h1, i, 1'b1);
		repeat (2) @(negedge clk);
		`CHK({half, lvl}, 4'h0)
		wr(1'b1, 2'h1, 32'h00005555, 1'b1);
		repeat (2) @(negedge clk);
		`CHK({half, lvl, vec}, {1'b1, 3'h5, 8'hC3})
		@(posedge clk) begin irq_lvl <= 3'h2; irq_vec <= 8'h96; end
		repeat (2) @(negedge clk);
		`CHK({half, lvl, vec}, {1'b1, 3'h2, 8'h96})
		for (int i = 0; i < 1100 && fill < 11'h400; i++) wr(1'b1, 2'h1, i, 1'b1);
		wr(1'b1, 2'h1, 32'h00006666, 1'b0);
		`CHK(fill, 11'h400)
		@(posedge clk) rdy <= 2'h1;
		for (int k = 0; k < 3000 && fill != 11'h000; k++) @(negedge clk);
		repeat (2) @(negedge clk);
		`CHK({fill, half, lvl}, 15'h0000)
		@(posedge clk) rdy <= 2'h0;
		$display("half-full test done");
	endtask
	initial begin
		rst_b = 1'b0;
		go = 1'b0;
		req = '0;
		sw = 1'b0;
		rdy = 2'h0;
		go_s = 1'b0;
		req_s = '0;
		rdy_s = 1'b0;
		irq_lvl = 3'h5;
		irq_vec = 8'hC3;
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		t_direct;
		t_buffer;
		t_single;
		t_local;
		t_half;
		stop_test;
	end
	// Longest test is about 5200 cycles
	initial begin
		#1_200_000;
		n_mismatch++;
		stop_test;
	end
endmodule
bind gcf_top gcf_checker #(.DEPTH(DEPTH), .HALF_LEVEL(HALF_LEVEL)) i_chk (
	.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_host(i_host), .o_host_ack(o_host_ack),
	.o_local_mode(o_local_mode), .o_dp0(o_dp0), .i_dp0_ready(i_dp0_ready), .o_dp1(o_dp1),
	.i_dp1_ready(i_dp1_ready), .i_irq_level(i_irq_level), .i_irq_vector(i_irq_vector),
	.o_irq_level(o_irq_level), .o_irq_vector(o_irq_vector), .o_half_full(o_half_full),
	.o_fill_count(o_fill_count));
`default_nettype wire

/* File: logic/gcf_mem.sv */
// Entry storage of the graphics command buffer, registered read port
`timescale 1ns/1ps
`default_nettype none
module gcf_mem #(
	parameter int W = 34,
	parameter int D = 1024,
	parameter int AW = 10
) (
	// Clock
	input wire logic i_clk_sys,
	// Write port
	input wire logic i_we,
	input wire logic [AW-1:0] i_waddr,
	input wire logic [W-1:0] i_wdata,
	// Read port
	input wire logic i_re,
	input wire logic [AW-1:0] i_raddr,
	output logic [W-1:0] o_rdata
);

	logic [W-1:0] mem [D];

	generate
		if (D > (1 << AW)) begin : g_chk
			$error("gcf_mem: depth exceeds address range");
		end
	endgenerate

	// Read data holds until the next read, so the head entry stays put
	always_ff @(posedge i_clk_sys) begin
		if (i_we) begin
			mem[i_waddr] <= i_wdata;
		end
		if (i_re) begin
			o_rdata <= mem[i_raddr];
		end
	end

endmodule
`default_nettype wire

/* File: logic/gcf_pkg.sv */
// Shared constants and carrier types of the graphics command buffer
package gcf_pkg;

	// ************************************************************
	// Buffer geometry
	// ************************************************************
	localparam int GCF_DEPTH = 1024;
	localparam int GCF_HALF_LEVEL = 512;
	localparam int GCF_DP_W = 16;
	localparam int GCF_HOST_W = 32;
	localparam int GCF_TGT_W = 2;

	// ************************************************************
	// Target select encodings (bit 0 first processor, bit 1 second)
	// ************************************************************
	localparam logic [1:0] GCF_TGT_NONE = 2'h0;
	localparam logic [1:0] GCF_TGT_DP0 = 2'h1;
	localparam logic [1:0] GCF_TGT_DP1 = 2'h2;
	localparam logic [1:0] GCF_TGT_BOTH = 2'h3;

	// ************************************************************
	// Interrupt and synchroniser constants
	// ************************************************************
	localparam logic [2:0] GCF_IRQ_NONE = 3'h0;
	localparam int GCF_SYNC_LEN = 3;

	// ************************************************************
	// Carrier types
	// ************************************************************
	typedef struct packed {
		logic valid;
		logic fifo_sel;
		logic [GCF_TGT_W-1:0] target;
		logic [GCF_HOST_W-1:0] data;
	} gcf_host_req_t;

	typedef struct packed {
		logic valid;
		logic [GCF_DP_W-1:0] data;
	} gcf_dp_t;

endpackage

/* File: logic/gcf_top.sv */
// Graphics command buffer between host bus slave and drawing processors
// Contract
// RL1: 1024 entries buffered between host and processors
// RL2: Address choice selects direct or buffered path
// RL3: Interrupt request raised at half-full level
// RL4: Two-processor variant: 32-bit entries, 4 Kbyte
// RL5: One write reaches either processor or both
// RL6: Single-processor variant: 16-bit entries, 2 Kbyte
// RL7: Host writes never wait for command execution; direct writes wait for a free stage, buffered writes wait while full
// RL8: Local switch position ignores all host accesses
// RL9: Interrupt forwarded with programmed level and vector
// RL10: Half-full set at 512 entries or more
// RL11: Low half first processor, high half second
`timescale 1ns/1ps
`default_nettype none
module gcf_top #(
	parameter int DEPTH = gcf_pkg::GCF_DEPTH,
	parameter int HALF_LEVEL = gcf_pkg::GCF_HALF_LEVEL,
	parameter bit DUAL = 1'b1
) (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	// Host write request, held until acknowledged
	input wire gcf_pkg::gcf_host_req_t i_host,
	output logic o_host_ack,
	// Run/local selector pin, high in local position
	input wire logic i_local_sw,
	output logic o_local_mode,
	// Drawing processor ports
	output gcf_pkg::gcf_dp_t o_dp0,
	input wire logic i_dp0_ready,
	output gcf_pkg::gcf_dp_t o_dp1,
	input wire logic i_dp1_ready,
	// Bus interrupter programming and request
	input wire logic [2:0] i_irq_level,
	input wire logic [7:0] i_irq_vector,
	output logic [2:0] o_irq_level,
	output logic [7:0] o_irq_vector,
	output logic o_half_full,
	output logic [$clog2(DEPTH):0] o_fill_count
);

	// ************************************************************
	// Derived sizes
	// ************************************************************
	localparam int AW = $clog2(DEPTH);
	localparam int DW = gcf_pkg::GCF_DP_W;
	localparam int TW = gcf_pkg::GCF_TGT_W;
	// RL4 RL6 entry width per variant
	localparam int EW = DUAL ? (2 * DW + TW) : DW;
	localparam logic [AW:0] DEPTH_C = (AW + 1)'(DEPTH);
	localparam logic [AW:0] HALF_C = (AW + 1)'(HALF_LEVEL);
	localparam int SL = gcf_pkg::GCF_SYNC_LEN;

	generate
		if ((1 << AW) != DEPTH || HALF_LEVEL < 1 || HALF_LEVEL > DEPTH) begin : g_chk
			$error("gcf_top: depth must be a power of two above half level");
		end
	endgenerate

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		logic [SL-1:0] sync;
		logic local_mode;
		logic ack;
		logic [AW-1:0] wr_ptr;
		logic [AW-1:0] rd_ptr;
		logic [AW:0] count;
		logic pend;
		gcf_pkg::gcf_dp_t dp0;
		gcf_pkg::gcf_dp_t dp1;
		logic half;
		logic [2:0] irq_level;
		logic [7:0] irq_vector;
	} gcf_state_t;

	gcf_state_t state_ff;
	gcf_state_t nxt_state;

	logic mem_we;
	logic mem_re;
	logic [EW-1:0] mem_wdata;
	logic [EW-1:0] mem_rdata;

	// RL1 storage of all entries
	gcf_mem #(
		.W(EW),
		.D(DEPTH),
		.AW(AW)
	) u_mem (
		.i_clk_sys(i_clk_sys),
		.i_we(mem_we),
		.i_waddr(state_ff.wr_ptr),
		.i_wdata(mem_wdata),
		.i_re(mem_re),
		.i_raddr(state_ff.rd_ptr),
		.o_rdata(mem_rdata)
	);

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		logic [TW-1:0] tgt;
		logic [TW-1:0] head_tgt;
		logic [DW-1:0] head_lo;
		logic [DW-1:0] head_hi;
		logic free0;
		logic free1;
		logic take;
		logic direct_fire;
		logic pop;
		logic [2*DW+TW-1:0] head_full;
		tgt = gcf_pkg::GCF_TGT_DP0;
		free0 = 1'b0;
		free1 = 1'b0;
		take = 1'b0;
		// Widened copy keeps the upper slices legal in the narrow variant
		head_full = (2*DW+TW)'(mem_rdata);
		head_tgt = gcf_pkg::GCF_TGT_DP0;
		head_lo = mem_rdata[DW-1:0];
		head_hi = '0;
		direct_fire = 1'b0;
		pop = 1'b0;
		nxt_state = state_ff;
		nxt_state.ack = 1'b0;
		mem_we = 1'b0;
		mem_re = 1'b0;
		mem_wdata = '0;

		// Mode follows the last stage only when the last two stages agree
		nxt_state.sync = {state_ff.sync[SL-2:0], i_local_sw};
		if (state_ff.sync[SL-2] == state_ff.sync[SL-1]) begin
			nxt_state.local_mode = state_ff.sync[SL-1];
		end

		// RL5 RL11 target of this write, empty select means first processor
		if (DUAL && i_host.target != gcf_pkg::GCF_TGT_NONE) begin
			tgt = i_host.target;
		end
		if (DUAL) begin
			head_tgt = head_full[2*DW+TW-1 -: TW];
			head_hi = head_full[2*DW-1 -: DW];
		end

		free0 = !state_ff.dp0.valid || i_dp0_ready;
		free1 = !state_ff.dp1.valid || i_dp1_ready;
		if (state_ff.dp0.valid && i_dp0_ready) begin
			nxt_state.dp0.valid = 1'b0;
		end
		if (state_ff.dp1.valid && i_dp1_ready) begin
			nxt_state.dp1.valid = 1'b0;
		end

		// RL8 no answer at all while in local position
		take = i_host.valid && !state_ff.local_mode && !state_ff.ack;

		// RL2 RL7 buffered path completes while entries wait
		if (take && i_host.fifo_sel && state_ff.count != DEPTH_C) begin
			mem_we = 1'b1;
			mem_wdata = DUAL ? EW'({tgt, i_host.data}) : EW'(i_host.data[DW-1:0]);
			nxt_state.wr_ptr = state_ff.wr_ptr + 1'b1;
			nxt_state.ack = 1'b1;
		end

		// RL2 direct path waits for the addressed stage only
		if (take && !i_host.fifo_sel && (!tgt[0] || free0) && (!tgt[1] || free1)) begin
			direct_fire = 1'b1;
			nxt_state.ack = 1'b1;
			if (tgt[0]) begin
				nxt_state.dp0 = '{valid: 1'b1, data: i_host.data[DW-1:0]};
			end
			if (tgt[1]) begin
				nxt_state.dp1 = '{valid: 1'b1, data: i_host.data[2*DW-1 -: DW]};
			end
		end

		// RL11 drain head entry; direct writes win the stage
		if (state_ff.pend && !direct_fire && (!head_tgt[0] || free0)
			&& (!head_tgt[1] || free1)) begin
			pop = 1'b1;
			nxt_state.pend = 1'b0;
			nxt_state.rd_ptr = state_ff.rd_ptr + 1'b1;
			if (head_tgt[0]) begin
				nxt_state.dp0 = '{valid: 1'b1, data: head_lo};
			end
			if (head_tgt[1]) begin
				nxt_state.dp1 = '{valid: 1'b1, data: head_hi};
			end
		end

		// Fetch ahead so the head sits in the read register
		if (!state_ff.pend && state_ff.count != '0) begin
			mem_re = 1'b1;
			nxt_state.pend = 1'b1;
		end

		// RL1 occupancy
		nxt_state.count = state_ff.count + (AW + 1)'(mem_we) - (AW + 1)'(pop);

		// RL3 RL10 half-full level tracks the count
		nxt_state.half = nxt_state.count >= HALF_C;
		// RL9 request on the programmed level, zero when quiet
		nxt_state.irq_level = nxt_state.half ? i_irq_level : gcf_pkg::GCF_IRQ_NONE;
		nxt_state.irq_vector = i_irq_vector;
	end

	// ************************************************************
	// Registers
	// ************************************************************
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign o_host_ack = state_ff.ack;
	assign o_local_mode = state_ff.local_mode;
	assign o_dp0 = state_ff.dp0;
	assign o_dp1 = state_ff.dp1;
	assign o_irq_level = state_ff.irq_level;
	assign o_irq_vector = state_ff.irq_vector;
	assign o_half_full = state_ff.half;
	assign o_fill_count = state_ff.count;

endmodule
`default_nettype wire
